// ---- hdl/ucad_decoder.sv ----
// alpha field decoder: byte stream in, 16-bit characters out
//
// Operation
// - '80' pairs bytes, first byte high half
// - '80' padding FF and lone byte ignored
// - '81' count, base is third byte shifted
// - '81' body: bit8 offset or 7-bit char
// - '82' count, base from bytes three, four
// - '82' body: bit8 offset or 7-bit char
// - emit at most count chars, fewer if the last byte comes first, FF valid
// - scheme chosen once per record
// - all three schemes supported
`timescale 1ns/1ps
`include "ucad_params.svh"
module ucad_decoder (
  input  wire logic        CLK,
  input  wire logic        RST_B,
  input  wire logic        START,
  input  wire logic        IN_VALID,
  input  wire logic [7:0]  IN_BYTE,
  input  wire logic        IN_LAST,
  output logic             IN_READY,
  output logic             CHAR_VALID,
  output logic      [15:0] CHAR_CODE,
  output logic             CHAR_WIDE,
  output logic             DONE,
  output logic             BUSY
);
  ucad_pkg::ucad_state_e  state_reg, state_next;
  ucad_pkg::ucad_scheme_e scheme_reg, scheme_next;
  logic [7:0]  count_reg, count_next;
  logic [15:0] base_reg, base_next;
  logic [7:0]  hold_reg, hold_next;
  logic        half_reg, half_next;
  logic        cv_reg, cv_next;
  logic [15:0] cc_reg, cc_next;
  logic        cw_reg, cw_next;
  logic        done_reg, done_next;
  logic [15:0] off_code;
  logic        off_wide;
  logic        take;

  ucad_offset_char u_off (
    .base (base_reg),
    .body (IN_BYTE),
    .code (off_code),
    .wide (off_wide)
  );

  // bytes are accepted while decoding; the done state holds until the next start
  assign IN_READY   = (state_reg != ucad_pkg::ST_DONE);
  assign take       = IN_VALID && IN_READY;
  assign CHAR_VALID = cv_reg;
  assign CHAR_CODE  = cc_reg;
  assign CHAR_WIDE  = cw_reg;
  assign DONE       = done_reg;
  assign BUSY       = (state_reg != ucad_pkg::ST_DONE);

  // next state and output computation
  always_comb
  begin
    state_next  = state_reg;
    scheme_next = scheme_reg;
    count_next  = count_reg;
    base_next   = base_reg;
    hold_next   = hold_reg;
    half_next   = half_reg;
    cv_next     = 1'b0;
    cc_next     = cc_reg;
    cw_next     = cw_reg;
    done_next   = 1'b0;
    if (START)
    begin
      state_next = ucad_pkg::ST_LEAD;
      half_next  = 1'b0;
    end
    else if (take)
    begin
      case (state_reg)
        ucad_pkg::ST_LEAD:
        begin
          half_next = 1'b0;
          // scheme fixed here for the whole record
          if (IN_BYTE == `UCAD_LEAD_PLAIN16)
          begin
            scheme_next = ucad_pkg::SCH_PLAIN16;
            state_next  = ucad_pkg::ST_BODY;
          end
          else if (IN_BYTE == `UCAD_LEAD_HALFPAGE)
          begin
            scheme_next = ucad_pkg::SCH_HALFPAGE;
            state_next  = ucad_pkg::ST_COUNT;
          end
          else if (IN_BYTE == `UCAD_LEAD_FULLBASE)
          begin
            scheme_next = ucad_pkg::SCH_FULLBASE;
            state_next  = ucad_pkg::ST_COUNT;
          end
          else
          begin
            // lead byte is itself the first 7-bit character
            scheme_next = ucad_pkg::SCH_DEFAULT;
            state_next  = ucad_pkg::ST_BODY;
            cv_next     = 1'b1;
            cc_next     = {9'h000, IN_BYTE[6:0]};
            cw_next     = 1'b0;
          end
          if (IN_LAST)
          begin
            state_next = ucad_pkg::ST_DONE;
            done_next  = 1'b1;
          end
        end
        ucad_pkg::ST_COUNT:
        begin
          count_next = IN_BYTE;
          state_next = ucad_pkg::ST_BASEA;
          if (IN_LAST)
          begin
            state_next = ucad_pkg::ST_DONE;
            done_next  = 1'b1;
          end
        end
        ucad_pkg::ST_BASEA:
        begin
          if (scheme_reg == ucad_pkg::SCH_HALFPAGE)
          begin
            base_next  = {1'b0, IN_BYTE, 7'h00};
            state_next = ucad_pkg::ST_BODY;
          end
          else
          begin
            base_next  = {IN_BYTE, 8'h00};
            state_next = ucad_pkg::ST_BASEB;
          end
          // a zero count ends the record once the header is read
          if (IN_LAST || (scheme_reg == ucad_pkg::SCH_HALFPAGE && count_reg == 8'h00))
          begin
            state_next = ucad_pkg::ST_DONE;
            done_next  = 1'b1;
          end
        end
        ucad_pkg::ST_BASEB:
        begin
          base_next  = {base_reg[15:8], IN_BYTE};
          state_next = ucad_pkg::ST_BODY;
          if (IN_LAST || count_reg == 8'h00)
          begin
            state_next = ucad_pkg::ST_DONE;
            done_next  = 1'b1;
          end
        end
        ucad_pkg::ST_BODY:
        begin
          case (scheme_reg)
            ucad_pkg::SCH_PLAIN16:
            begin
              if (!half_reg)
              begin
                hold_next = IN_BYTE;
                half_next = 1'b1;
              end
              else
              begin
                half_next = 1'b0;
                // an all-FF pair is padding, not a character
                if (!(hold_reg == `UCAD_PAD_BYTE && IN_BYTE == `UCAD_PAD_BYTE))
                begin
                  cv_next = 1'b1;
                  cc_next = {hold_reg, IN_BYTE};
                  cw_next = 1'b1;
                end
              end
              // a lone trailing byte never forms a character
              if (IN_LAST)
              begin
                state_next = ucad_pkg::ST_DONE;
                done_next  = 1'b1;
              end
            end
            ucad_pkg::SCH_HALFPAGE, ucad_pkg::SCH_FULLBASE:
            begin
              // FF inside the count is a real offset character
              cv_next    = 1'b1;
              cc_next    = off_code;
              cw_next    = off_wide;
              count_next = count_reg - 8'h01;
              if (count_reg == 8'h01 || IN_LAST)
              begin
                state_next = ucad_pkg::ST_DONE;
                done_next  = 1'b1;
              end
            end
            default:
            begin
              cv_next = 1'b1;
              cc_next = {9'h000, IN_BYTE[6:0]};
              cw_next = 1'b0;
              if (IN_LAST)
              begin
                state_next = ucad_pkg::ST_DONE;
                done_next  = 1'b1;
              end
            end
          endcase
        end
        default:
        begin
          state_next = ucad_pkg::ST_DONE;
        end
      endcase
    end
  end

  // done pulses with the character strobe of the last taken byte, or alone if that byte yields no character
  always_ff @(posedge CLK or negedge RST_B)
  begin
    if (!RST_B)
    begin
      state_reg  <= ucad_pkg::ST_DONE;
      scheme_reg <= ucad_pkg::SCH_DEFAULT;
      count_reg  <= 8'h00;
      base_reg   <= 16'h0000;
      hold_reg   <= 8'h00;
      half_reg   <= 1'b0;
      cv_reg     <= 1'b0;
      cc_reg     <= 16'h0000;
      cw_reg     <= 1'b0;
      done_reg   <= 1'b0;
    end
    else
    begin
      state_reg  <= state_next;
      scheme_reg <= scheme_next;
      count_reg  <= count_next;
      base_reg   <= base_next;
      hold_reg   <= hold_next;
      half_reg   <= half_next;
      cv_reg     <= cv_next;
      cc_reg     <= cc_next;
      cw_reg     <= cw_next;
      done_reg   <= done_next;
    end
  end
endmodule

// ---- hdl/ucad_offset_char.sv ----
// combines a base pointer and one body byte into a character
`timescale 1ns/1ps
`include "ucad_params.svh"
module ucad_offset_char (
  input  wire logic [15:0] base,
  input  wire logic [7:0]  body,
  output logic      [15:0] code,
  output logic             wide
);
  // high bit set selects an offset from the base pointer, else a 7-bit character
  always_comb
  begin
    wide = body[`UCAD_HIGH_BIT];
    if (wide)
      code = base + {9'h000, body[6:0]};
    else
      code = {9'h000, body[6:0]};
  end
endmodule

// ---- hdl/ucad_params.svh ----
// constants for the alpha field decoder
`ifndef UCAD_PARAMS_SVH
`define UCAD_PARAMS_SVH
`define UCAD_LEAD_PLAIN16 8'h80
`define UCAD_LEAD_HALFPAGE 8'h81
`define UCAD_LEAD_FULLBASE 8'h82
`define UCAD_PAD_BYTE 8'hFF
`define UCAD_HIGH_BIT 7
`define UCAD_HALF_SHIFT 7
`endif

// ---- hdl/ucad_pkg.sv ----
// types for the alpha field decoder
package ucad_pkg;
  typedef enum logic [2:0] {
    ST_LEAD  = 3'h0,
    ST_COUNT = 3'h1,
    ST_BASEA = 3'h2,
    ST_BASEB = 3'h3,
    ST_BODY  = 3'h4,
    ST_DONE  = 3'h5
  } ucad_state_e;
  typedef enum logic [1:0] {
    SCH_DEFAULT  = 2'h0,
    SCH_PLAIN16  = 2'h1,
    SCH_HALFPAGE = 2'h2,
    SCH_FULLBASE = 2'h3
  } ucad_scheme_e;
endpackage

// ---- tb/ucad_byte_src.sv ----
// record byte source model for the alpha field decoder
`timescale 1ns/1ps
module ucad_byte_src (
  input  wire logic       CLK,
  input  wire logic       START,
  input  wire logic       IN_READY,
  input  wire logic       SLOW,
  output logic            IN_VALID,
  output logic      [7:0] IN_BYTE,
  output logic            IN_LAST
);
  logic [7:0] q[$];
  logic       gap = 1'b0;
  // a taken byte leaves the queue; slow mode idles a cycle after each
  always @(posedge CLK)
  begin
    gap = 1'b0;
    if (IN_VALID && IN_READY && !START)
    begin
      void'(q.pop_front());
      gap = SLOW;
    end
  end
  // idle cycles flip the byte so stale data is never read as valid
  always @(negedge CLK)
  begin
    IN_VALID <= q.size() > 0 && !gap;
    IN_BYTE  <= (q.size() > 0 && !gap) ? q[0] : ~IN_BYTE;
    IN_LAST  <= q.size() == 1 && !gap;
  end
  initial
  begin
    IN_VALID = 1'b0;
    IN_BYTE  = 8'h00;
    IN_LAST  = 1'b0;
  end
endmodule

// ---- tb/ucad_decoder_asserts.sv ----
// port assertions for the alpha field decoder
`timescale 1ns/1ps
module ucad_decoder_chk (
  input wire logic        CLK,
  input wire logic        RST_B,
  input wire logic        START,
  input wire logic        IN_VALID,
  input wire logic [7:0]  IN_BYTE,
  input wire logic        IN_READY,
  input wire logic        CHAR_VALID,
  input wire logic [15:0] CHAR_CODE,
  input wire logic        CHAR_WIDE,
  input wire logic        DONE
);
  default clocking cb @(posedge CLK);
  endclocking
  default disable iff (!RST_B);
  // a byte counts as taken only without a start in the same cycle
  wire       take = IN_VALID && IN_READY && !START;
  wire [6:0] lo7  = IN_BYTE[6:0];
  a_char_cause: assert property (CHAR_VALID |-> $past(take))
    else $error("char strobe without taken byte");
  a_done_cause: assert property (DONE |-> $past(take))
    else $error("done without taken byte");
  a_done_pulse: assert property (DONE |=> !DONE)
    else $error("done longer than one cycle");
  a_done_idle: assert property (DONE |-> !IN_READY)
    else $error("bytes still accepted after done");
  a_start_ready: assert property (START |=> IN_READY)
    else $error("record not opened by start");
  a_code_hold: assert property (!CHAR_VALID |-> $stable(CHAR_CODE) && $stable(CHAR_WIDE))
    else $error("character changed between strobes");
  a_narrow_top: assert property (CHAR_VALID && !CHAR_WIDE |-> CHAR_CODE[15:7] == 9'h000)
    else $error("narrow char wider than seven bits");
  a_narrow_low: assert property (CHAR_VALID && !CHAR_WIDE |-> CHAR_CODE[6:0] == $past(lo7))
    else $error("narrow char differs from its byte");
endmodule
bind ucad_decoder ucad_decoder_chk u_chk (.CLK(CLK), .RST_B(RST_B), .START(START),
  .IN_VALID(IN_VALID), .IN_BYTE(IN_BYTE), .IN_READY(IN_READY), .CHAR_VALID(CHAR_VALID),
  .CHAR_CODE(CHAR_CODE), .CHAR_WIDE(CHAR_WIDE), .DONE(DONE));

// ---- tb/ucad_decoder_tb.sv ----
// self-checking bench for the alpha field decoder
`timescale 1ns/1ps
`define UCAD_CHK(a, b) begin samples_checked++; if ((a) !== (b)) begin n_errors++; \
  $display("CHECK FAILED %0t got %h exp %h", $time, a, b); end end
module ucad_decoder_tb;
  typedef struct {logic [71:0] fb; int nb; logic [99:0] ex; int nc;} ucad_row_s;
  logic        CLK, RST_B, START, SLOW, IN_VALID, IN_LAST, IN_READY;
  logic        CHAR_VALID, CHAR_WIDE, DONE, BUSY;
  logic [7:0]  IN_BYTE;
  logic [15:0] CHAR_CODE;
  int          n_errors = 0, samples_checked = 0, cycles = 0;
  // field bytes right aligned; each char is {wide nibble, code}; writers pad with FF
  ucad_row_s   rows [7] = '{
    '{72'h8105135395A641FF, 8, 100'h00053_10995_109A6_00041_109FF, 5},
    '{72'h820505302D82D32D31, 9, 100'h0002D_10532_10583_0002D_00031, 5},
    '{72'h8009800041FFFF, 7, 100'h10980_10041, 2},
    '{72'h800995FF, 4, 100'h10995, 1},
    '{72'h41C3, 2, 100'h00041_00043, 2},
    '{72'h810013, 3, 100'h0, 0},
    '{72'h81051395, 4, 100'h10995, 1}};
  ucad_decoder u_ucad_decoder (.CLK(CLK), .RST_B(RST_B), .START(START),
    .IN_VALID(IN_VALID), .IN_BYTE(IN_BYTE), .IN_LAST(IN_LAST), .IN_READY(IN_READY),
    .CHAR_VALID(CHAR_VALID), .CHAR_CODE(CHAR_CODE), .CHAR_WIDE(CHAR_WIDE),
    .DONE(DONE), .BUSY(BUSY));
  ucad_byte_src u_ucad_byte_src (.CLK(CLK), .START(START), .IN_READY(IN_READY),
    .SLOW(SLOW), .IN_VALID(IN_VALID), .IN_BYTE(IN_BYTE), .IN_LAST(IN_LAST));
  initial
  begin
    CLK = 1'b0;
    forever #2.5 CLK = ~CLK;
  end
  task stop_test();
    $display("checks %0d errors %0d", samples_checked, n_errors);
    if (n_errors == 0 && samples_checked > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  // one record: start, queue its bytes, gather characters until done
  task run_row(input int r);
    int k, t;
    @(negedge CLK);
    START = 1'b1;
    for (k = 0; k < rows[r].nb; k++)
      u_ucad_byte_src.q.push_back(rows[r].fb[8*(rows[r].nb-1-k) +: 8]);
    @(negedge CLK);
    START = 1'b0;
    k = 0;
    for (t = 0; t < 40 && DONE !== 1'b1; t++)
    begin
      @(posedge CLK);
      #1;
      if (CHAR_VALID === 1'b1)
      begin
        `UCAD_CHK(({3'h0, CHAR_WIDE, CHAR_CODE}), rows[r].ex[20*(rows[r].nc-1-k) +: 20])
        k++;
      end
    end
    `UCAD_CHK(k, rows[r].nc)
    `UCAD_CHK(DONE, 1'b1)
    `UCAD_CHK(BUSY, 1'b0)
    u_ucad_byte_src.q.delete();
  endtask
  // a hang counts as a mismatch
  always @(posedge CLK)
  begin
    cycles++;
    if (cycles == 3000)
    begin
      n_errors++;
      stop_test();
    end
  end
  initial
  begin
    START = 1'b0;
    SLOW = 1'b0;
    RST_B = 1'b0;
    repeat (2) @(negedge CLK);
    RST_B = 1'b1;
    for (int s = 0; s < 2; s++)
    begin
      SLOW = s[0];
      foreach (rows[i]) run_row(i);
    end
    // reset in mid-record clears IN_READY, BUSY, CHAR_VALID, DONE and CHAR_CODE
    @(negedge CLK);
    START = 1'b1;
    u_ucad_byte_src.q.push_back(8'h80);
    u_ucad_byte_src.q.push_back(8'h09);
    @(negedge CLK);
    START = 1'b0;
    @(negedge CLK);
    RST_B = 1'b0;
    #1;
    `UCAD_CHK(({IN_READY, BUSY, CHAR_VALID, DONE, CHAR_CODE}), 20'h00000)
    u_ucad_byte_src.q.delete();
    @(negedge CLK);
    RST_B = 1'b1;
    run_row(1);
    stop_test();
  end
endmodule
